// ===== verilog/scpr_regs.sv
`timescale 1ns/1ps
`include "scpr_map.svh"

module scpr_regs #(
	parameter int unsigned RST_CYCLES = `SCPR_SWRST_CYCLES
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// serial port pins
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_sdi,
	output logic            spi_sdo,
	output logic            spi_sdo_oe,
	// device control outputs
	output logic            chip_reset_busy,
	output logic            power_down,
	output logic [1:0]      device_mode
);

	localparam int unsigned CW = $clog2(RST_CYCLES + 1);
	localparam int unsigned AW = `SCPR_ADDR_W;

	logic [2:0] pins_s; // synchronised sclk, cs_n, sdi
	logic       sclk_s;
	logic       cs_n_s;
	logic       sdi_s;

	// register state
	logic [7:0]               cfga_q, cfga_d;     // interface_config_a storage
	logic [7:0]               devcfg_q, devcfg_d; // device_power_config
	logic [7:0]               user_q, user_d;     // user serial configuration
	logic [CW-1:0]            rcnt_q, rcnt_d;     // soft reset countdown
	logic                     busy_q, busy_d;     // soft reset in progress
	logic                     pd_q, pd_d;         // power-down level
	// serial engine state
	scpr_pkg::scpr_phase_t    phase_q, phase_d;   // header or data
	logic [14:0]              hdr_q, hdr_d;       // header shift register
	logic [3:0]               bcnt_q, bcnt_d;     // bit counter
	logic                     rd_q, rd_d;         // frame is a read
	logic [AW-1:0]            addr_q, addr_d;     // current register address
	logic [7:0]               rx_q, rx_d;         // incoming data byte
	logic [7:0]               tx_q, tx_d;         // outgoing data byte
	logic                     sclk_prev_q, sclk_prev_d;
	// combinational helpers
	logic                     edge_r;
	logic                     edge_f;
	logic [7:0]               wdat;

	// pin synchroniser
	scpr_sync #(
		.WIDTH(3)
	) u_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.async_in({spi_sclk, spi_cs_n, spi_sdi}),
		.sync_out(pins_s)
	);

	assign sclk_s = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign sdi_s  = pins_s[0];

	// read data for an address; unmapped reads as zero
	function automatic logic [7:0] rd_mux(input logic [AW-1:0] a, input logic [7:0] ca,
			input logic [7:0] dc, input logic [7:0] us);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`SCPR_OFS_IFACE_CFG_A: begin
				v = ca;
				v[`SCPR_CFGA_SOFT_RST] = 1'b0; // self-clearing, reads zero
				v[`SCPR_CFGA_SEP_OUT]  = 1'b1; // always one
			end
			`SCPR_OFS_DEV_PWR_CFG: begin
				v = dc;
			end
			`SCPR_OFS_USER_SPI: begin
				v = us;
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	// next state of registers and serial engine
	always_comb begin
		cfga_d      = cfga_q;
		devcfg_d    = devcfg_q;
		user_d      = user_q;
		rcnt_d      = rcnt_q;
		phase_d     = phase_q;
		hdr_d       = hdr_q;
		bcnt_d      = bcnt_q;
		rd_d        = rd_q;
		addr_d      = addr_q;
		rx_d        = rx_q;
		tx_d        = tx_q;
		sclk_prev_d = sclk_s;
		edge_r      = sclk_s & ~sclk_prev_q;
		edge_f      = ~sclk_s & sclk_prev_q;
		wdat        = {rx_q[6:0], sdi_s};
		if (rcnt_q != '0) begin
			// registers, phase, bit count, read flag and tx byte held at defaults while the soft reset runs
			rcnt_d   = rcnt_q - CW'(1);
			cfga_d   = `SCPR_RST_IFACE_CFG_A; // ascend back to one
			devcfg_d = `SCPR_RST_DEV_PWR_CFG; // mode back to normal
			user_d   = `SCPR_RST_USER_SPI;
			phase_d  = scpr_pkg::SCPR_PH_HEADER;
			bcnt_d   = 4'h0;
			rd_d     = 1'b0;
			tx_d     = 8'h00;
		end else if (cs_n_s) begin
			// frame idle: restart header on next select
			phase_d = scpr_pkg::SCPR_PH_HEADER;
			bcnt_d  = 4'h0;
			rd_d    = 1'b0;
			tx_d    = 8'h00;
		end else if (edge_r) begin
			unique case (phase_q)
				scpr_pkg::SCPR_PH_HEADER: begin
					// collect read flag and 15-bit address
					hdr_d  = {hdr_q[13:0], sdi_s};
					bcnt_d = bcnt_q + 4'h1;
					if (bcnt_q == 4'hF) begin
						rd_d    = hdr_q[14];
						addr_d  = {hdr_q[13:0], sdi_s};
						phase_d = scpr_pkg::SCPR_PH_DATA;
						bcnt_d  = 4'h0;
					end
				end
				scpr_pkg::SCPR_PH_DATA: begin
					rx_d   = wdat;
					bcnt_d = {1'b0, bcnt_q[2:0] + 3'h1};
					if (bcnt_q[2:0] == 3'h7) begin
						if (!rd_q) begin
							unique case (addr_q)
								`SCPR_OFS_IFACE_CFG_A: begin
									if (wdat[`SCPR_CFGA_SOFT_RST]) begin
										// start reset; bit never stored
										rcnt_d = CW'(RST_CYCLES);
									end else begin
										cfga_d = wdat; // direction bit stored
									end
								end
								`SCPR_OFS_DEV_PWR_CFG: begin
									devcfg_d = wdat; // mode field
								end
								`SCPR_OFS_USER_SPI: begin
									user_d = wdat;
								end
								default: begin
									user_d = user_q; // unmapped write ignored
								end
							endcase
						end
						// step address after each byte
						if (user_q[`SCPR_USER_ADDR_HOLD]) begin
							addr_d = addr_q; // frozen, overrides direction
						end else if (cfga_q[`SCPR_CFGA_ASCEND]) begin
							addr_d = addr_q + AW'(1); // ascending
						end else begin
							addr_d = addr_q - AW'(1); // descending
						end
					end
				end
			endcase
		end else if (edge_f && phase_q == scpr_pkg::SCPR_PH_DATA) begin
			// read data leaves on the separate output line
			if (bcnt_q[2:0] == 3'h0) begin
				tx_d = rd_mux(addr_q, cfga_q, devcfg_q, user_q);
			end else begin
				tx_d = {tx_q[6:0], 1'b0};
			end
		end
		busy_d = (rcnt_d != '0);
		pd_d   = (devcfg_d[1:0] == `SCPR_MODE_PWR_DOWN); // full power-down
	end

	// register everything
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfga_q      <= `SCPR_RST_IFACE_CFG_A;
			devcfg_q    <= `SCPR_RST_DEV_PWR_CFG;
			user_q      <= `SCPR_RST_USER_SPI;
			rcnt_q      <= '0;
			busy_q      <= 1'b0;
			pd_q        <= 1'b0;
			phase_q     <= scpr_pkg::SCPR_PH_HEADER;
			hdr_q       <= 15'h0000;
			bcnt_q      <= 4'h0;
			rd_q        <= 1'b0;
			addr_q      <= '0;
			rx_q        <= 8'h00;
			tx_q        <= 8'h00;
			sclk_prev_q <= 1'b0;
		end else begin
			cfga_q      <= cfga_d;
			devcfg_q    <= devcfg_d;
			user_q      <= user_d;
			rcnt_q      <= rcnt_d;
			busy_q      <= busy_d;
			pd_q        <= pd_d;
			phase_q     <= phase_d;
			hdr_q       <= hdr_d;
			bcnt_q      <= bcnt_d;
			rd_q        <= rd_d;
			addr_q      <= addr_d;
			rx_q        <= rx_d;
			tx_q        <= tx_d;
			sclk_prev_q <= sclk_prev_d;
		end
	end

	// outputs
	assign spi_sdo         = tx_q[7];
	assign spi_sdo_oe      = ~cs_n_s & rd_q & (phase_q == scpr_pkg::SCPR_PH_DATA);
	assign chip_reset_busy = busy_q;
	assign power_down      = pd_q;
	assign device_mode     = devcfg_q[1:0];

endmodule

// ===== common/scpr_map.svh
`ifndef SCPR_MAP_SVH
`define SCPR_MAP_SVH

// register offsets on the serial port
`define SCPR_ADDR_W          15
`define SCPR_OFS_IFACE_CFG_A 15'h0000
`define SCPR_OFS_DEV_PWR_CFG 15'h0002
`define SCPR_OFS_USER_SPI    15'h0010

// field positions
`define SCPR_CFGA_SOFT_RST   7
`define SCPR_CFGA_ASCEND     5
`define SCPR_CFGA_SEP_OUT    4
`define SCPR_USER_ADDR_HOLD  0

// reset values
`define SCPR_RST_IFACE_CFG_A 8'h30
`define SCPR_RST_DEV_PWR_CFG 8'h00
`define SCPR_RST_USER_SPI    8'h00

// device mode field encodings
`define SCPR_MODE_NORMAL     2'h0
`define SCPR_MODE_PWR_DOWN   2'h3

// software reset interval
`define SCPR_CLK_PERIOD_NS   10
`define SCPR_SWRST_TIME_NS   750
`define SCPR_SWRST_CYCLES    (`SCPR_SWRST_TIME_NS / `SCPR_CLK_PERIOD_NS)

`endif

// ===== common/scpr_pkg.sv
package scpr_pkg;

	// phase of a serial frame
	typedef enum logic {
		SCPR_PH_HEADER,
		SCPR_PH_DATA
	} scpr_phase_t;

endpackage

// ===== verilog/scpr_sync.sv
`timescale 1ns/1ps

// two-flop synchroniser for pin inputs
module scpr_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// asynchronous inputs and their synchronised copies
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q; // second stage
	logic [WIDTH-1:0] sync_d;

	// next values of both stages
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule

// ===== dv/scpr_regs_asserts.sv
`timescale 1ns/1ps
// pin-level checks of the register bank
module scpr_regs_chk #(
	parameter int unsigned RST_CYCLES = 75
) (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// serial pins
	input wire logic       spi_sclk,
	input wire logic       spi_cs_n,
	input wire logic       spi_sdi,
	input wire logic       spi_sdo,
	input wire logic       spi_sdo_oe,
	// control outputs
	input wire logic       chip_reset_busy,
	input wire logic       power_down,
	input wire logic [1:0] device_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [31:0] bcnt_q; // busy cycles seen
	logic [31:0] bcnt_d;
	// count cycles of the reset interval
	always_comb begin
		bcnt_d = chip_reset_busy ? bcnt_q + 32'h0000_0001 : 32'h0000_0000;
	end
	always_ff @(posedge core_clk) begin
		bcnt_q <= rst ? 32'h0000_0000 : bcnt_d;
	end
	a_pd_on: assert property ((device_mode == 2'h3) [*2] |-> power_down)
		else $error("power down missing");
	a_pd_off: assert property ((device_mode != 2'h3) [*2] |-> !power_down)
		else $error("power down without mode three");
	a_busy_dflt: assert property (chip_reset_busy |=> device_mode == 2'h0 && !power_down)
		else $error("state kept through soft reset");
	a_busy_no_oe: assert property (chip_reset_busy |-> !spi_sdo_oe)
		else $error("output driven during soft reset");
	a_oe_needs_cs: assert property (spi_cs_n [*4] |-> !spi_sdo_oe)
		else $error("output driven while deselected");
	a_mode_idle: assert property (spi_cs_n [*6] |-> $stable(device_mode))
		else $error("mode moved without a frame");
	a_busy_len: assert property (chip_reset_busy |-> bcnt_q < RST_CYCLES)
		else $error("reset interval too long");
	a_busy_full: assert property ($fell(chip_reset_busy) |-> bcnt_q == RST_CYCLES)
		else $error("reset interval wrong length");
	c_pd: cover property ($rose(power_down));
	c_busy: cover property ($fell(chip_reset_busy));
	c_read: cover property ($rose(spi_sdo_oe));
endmodule

bind scpr_regs scpr_regs_chk #(.RST_CYCLES(RST_CYCLES)) u_chk (.core_clk(core_clk),
	.rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
	.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .chip_reset_busy(chip_reset_busy),
	.power_down(power_down), .device_mode(device_mode));

// ===== dv/scpr_host.sv
`timescale 1ns/1ps
// serial host: mode 0 frames, slow enough for the synchroniser
module scpr_host (
	// clock
	input  wire logic core_clk,
	// serial pins
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_sdi,
	input  wire logic spi_sdo
);
	// idle: deselected, clock low
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end
	// wait n edges, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// header then nb bytes; wd holds data msb first
	task automatic xfer(input logic rw, input logic [14:0] a, input logic [15:0] wd,
		input int nb, output logic [15:0] rd);
		logic [31:0] sh;
		sh = {rw, a, wd};
		rd = 16'h0000;
		spi_cs_n = 1'b0;
		for (int i = 0; i < 16 + 8 * nb; i++) begin
			spi_sdi = sh[31 - i];
			tick(6);
			rd = {rd[14:0], spi_sdo}; // read data from the output line only
			spi_sclk = 1'b1;
			tick(6);
			spi_sclk = 1'b0;
		end
		tick(6);
		spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi; // released line shows no stale bit
		tick(6);
	endtask
endmodule

// ===== dv/test_spi_config_and_power_mode_regs.sv
`timescale 1ns/1ps
module test_spi_config_and_power_mode_regs;
	logic        core_clk;
	logic        rst;
	logic        spi_sclk;
	logic        spi_cs_n;
	logic        spi_sdi;
	logic        spi_sdo;
	logic        spi_sdo_oe;
	logic        chip_reset_busy;
	logic        power_down;
	logic [1:0]  device_mode;
	logic [15:0] rd;
	logic        line_sdo; // data line as the host sees it
	int          num_errors;
	int          checks_done;
	scpr_regs dut (.core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe), .chip_reset_busy(chip_reset_busy),
		.power_down(power_down), .device_mode(device_mode));
	scpr_host host (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi), .spi_sdo(line_sdo));
	// an undriven line shows the inverse of the last bit, so a read outside oe fails
	assign line_sdo = spi_sdo_oe ? spi_sdo : ~spi_sdo;
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, {d, 8'h00}, 1, rd);
	endtask
	task automatic rd1(input logic [14:0] a, input logic [7:0] exp);
		host.xfer(1'b1, a, 16'h0000, 1, rd);
		check({8'h00, rd[7:0]}, {8'h00, exp});
	endtask
	// values after power-up
	task automatic t_defaults();
		rd1(15'h0000, 8'h30);
		rd1(15'h0002, 8'h00);
		check({14'h0000, device_mode}, 16'h0000);
	endtask
	// every mode code
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			wr(15'h0002, 8'(m));
			check({14'h0000, device_mode}, 16'(m));
			check({15'h0000, power_down}, 16'(m == 3));
		end
	endtask
	// streamed reads up, down and held
	task automatic t_stream();
		wr(15'h0002, 8'h01);
		host.xfer(1'b1, 15'h0001, 16'h0000, 2, rd);
		check(rd, 16'h0001);
		wr(15'h0000, 8'h00);
		host.xfer(1'b1, 15'h0001, 16'h0000, 2, rd);
		check(rd, 16'h0010);
		wr(15'h0010, 8'h01);
		host.xfer(1'b1, 15'h0002, 16'h0000, 2, rd);
		check(rd, 16'h0101);
	endtask
	// soft reset from a changed state
	task automatic t_soft();
		int n;
		wr(15'h0002, 8'h03);
		wr(15'h0000, 8'h80);
		n = 0;
		check({15'h0000, chip_reset_busy}, 16'h0001);
		while (chip_reset_busy === 1'b1 && n < 200) begin // idle the port
			host.tick(1);
			n++;
		end
		check(16'(n < 75), 16'h0001);
		check({15'h0000, power_down}, 16'h0000);
		rd1(15'h0000, 8'h30);
		rd1(15'h0002, 8'h00);
		rd1(15'h0010, 8'h00);
	endtask
	// hardware reset in mid-run from a changed state
	task automatic t_hard();
		wr(15'h0000, 8'h00);
		rst = 1'b1;
		host.tick(12);
		rst = 1'b0;
		host.tick(3);
		check({14'h0000, device_mode}, 16'h0000);
		check({15'h0000, power_down}, 16'h0000);
		rd1(15'h0000, 8'h30);
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		num_errors = 0;
		checks_done = 0;
		rst = 1'b1;
		repeat (12) @(posedge core_clk);
		#1;
		rst = 1'b0;
		host.tick(3);
		t_defaults();
		t_modes();
		t_hard();
		t_stream();
		t_soft();
		conclude();
	end
	// watchdog
	initial begin
		#200000;
		num_errors++;
		conclude();
	end
endmodule
